/* File: inc/flp_pkg.sv */
package flp_pkg;
  // register addresses on the special-function bus
  localparam logic [7:0] FLP_ADDR_ENABLE = 8'hA8;
  localparam logic [7:0] FLP_ADDR_PRIO_LOW = 8'hB8;
  localparam logic [7:0] FLP_ADDR_PRIO_UPPER = 8'hB7;
  // reset values
  localparam logic [7:0] FLP_ENABLE_RST = 8'h00;
  localparam logic [7:0] FLP_PRIO_RST = 8'h00;
  // enable register fields
  localparam int FLP_GLOBAL_BIT = 7;
  localparam logic [7:0] FLP_ENABLE_WMASK = 8'hBF;
  // source count and levels
  localparam int FLP_NSRC = 6;
  localparam int FLP_NLVL = 4;
  // fixed vectors in polling order
  localparam logic [7:0] FLP_VEC_BASE = 8'h03;
  localparam logic [7:0] FLP_VEC_STEP = 8'h08;
  // source index of the two external pins
  localparam int FLP_SRC_EXT0 = 0;
  localparam int FLP_SRC_EXT1 = 2;

  typedef logic [1:0] flp_level_t;

  // special-function register access from the cpu core
  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } flp_sfr_s;

  // cpu handshake: grant of a vector, and return from a routine
  typedef struct packed {
    logic take;
    logic ret;
  } flp_cpu_s;
endpackage

/* File: rtl/flp_select.sv */
`timescale 1ns/1ps
// ====================================================
// per-source level encode and polling-order pick
module flp_select (
  input wire logic [5:0] req,
  input wire logic [5:0] prio_low,
  input wire logic [5:0] prio_upper,
  output logic found,
  output logic [2:0] idx,
  output flp_pkg::flp_level_t lvl
);
  import flp_pkg::*;

  flp_level_t src_lvl [FLP_NSRC];

  // upper bit above lower bit gives level 0..3
  genvar g;
  generate
    for (g = 0; g < FLP_NSRC; g++) begin : g_lvl
      assign src_lvl[g] = {prio_upper[g], prio_low[g]};
    end
  endgenerate

  // highest level wins, then lowest index within the level
  always_comb begin
    found = 1'b0;
    idx = 3'h0;
    lvl = 2'h0;
    for (int i = 0; i < FLP_NSRC; i++) begin
      if (req[i] && (!found || src_lvl[i] > lvl)) begin
        found = 1'b1;
        idx = 3'(i);
        lvl = src_lvl[i];
      end
    end
  end
endmodule // flp_select

/* File: rtl/flp_irq_ctrl.sv */
`timescale 1ns/1ps
// How it works
// - Six sources are arbitrated across four priority levels.
// - The upper priority register at B7H gives each source its high level bit.
// - Level is upper bit then lower bit: 00 lowest up to 11 highest.
// - A request is taken only while no routine of equal or higher level is in service.
// - A request blocked by an equal or higher routine stays pending until that routine ends.
// - A request above the running routine's level preempts it.
// - Finishing a preempting routine resumes the suspended lower one, keeping nesting.
// - An external flag is cleared on vectoring only in transition mode.
module flp_irq_ctrl (
  input wire logic clk_sys,
  input wire logic resetn,
  input flp_pkg::flp_sfr_s sfr,
  output logic [7:0] sfr_rdata,
  input wire logic [5:0] src_flag,
  input wire logic ext0_edge_mode,
  input wire logic ext1_edge_mode,
  input flp_pkg::flp_cpu_s cpu,
  output logic irq_pending,
  output logic [7:0] irq_vector,
  output logic [1:0] ext_flag_clear,
  output logic [3:0] in_service
);
  import flp_pkg::*;

  logic rst_meta_reg;
  logic rst_n_reg;
  logic [7:0] enable_reg;
  logic [5:0] priority_low_reg;
  logic [5:0] priority_upper_reg;
  logic [3:0] in_service_reg;
  logic [7:0] sfr_rdata_reg;
  logic [1:0] ext_clear_reg;
  logic [5:0] req;
  logic found;
  logic [2:0] idx;
  flp_level_t lvl;
  logic allowed;
  logic grant;
  logic [3:0] above_mask;
  logic [3:0] top_bit;

  // ====================================================
  // reset release through two flip-flops
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      rst_meta_reg <= 1'b0;
      rst_n_reg <= 1'b0;
    end else begin
      rst_meta_reg <= 1'b1;
      rst_n_reg <= rst_meta_reg;
    end
  end

  // ====================================================
  // register writes
  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      enable_reg <= FLP_ENABLE_RST;
      priority_low_reg <= FLP_PRIO_RST[5:0];
      priority_upper_reg <= FLP_PRIO_RST[5:0];
    end else if (sfr.wr) begin
      case (sfr.addr)
        FLP_ADDR_ENABLE: enable_reg <= sfr.wdata & FLP_ENABLE_WMASK;
        FLP_ADDR_PRIO_LOW: priority_low_reg <= sfr.wdata[5:0];
        FLP_ADDR_PRIO_UPPER: priority_upper_reg <= sfr.wdata[5:0];
        default: ;
      endcase
    end
  end

  // register reads, reserved bits as zero
  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      sfr_rdata_reg <= 8'h00;
    end else if (sfr.rd) begin
      case (sfr.addr)
        FLP_ADDR_ENABLE: sfr_rdata_reg <= enable_reg;
        FLP_ADDR_PRIO_LOW: sfr_rdata_reg <= {2'b00, priority_low_reg};
        FLP_ADDR_PRIO_UPPER: sfr_rdata_reg <= {2'b00, priority_upper_reg};
        default: sfr_rdata_reg <= 8'h00;
      endcase
    end
  end

  // ====================================================
  // masking and arbitration
  assign req = src_flag & enable_reg[5:0] & {FLP_NSRC{enable_reg[FLP_GLOBAL_BIT]}};

  flp_select u_select (
    .req(req),
    .prio_low(priority_low_reg),
    .prio_upper(priority_upper_reg),
    .found(found),
    .idx(idx),
    .lvl(lvl)
  );

  // levels strictly above the winner must all be idle, its own too
  always_comb begin
    above_mask = 4'h0;
    for (int i = 0; i < FLP_NLVL; i++) begin
      above_mask[i] = (2'(i) >= lvl);
    end
  end

  assign allowed = found && ((in_service_reg & above_mask) == 4'h0);
  assign grant = allowed && cpu.take;

  // isolate highest in-service level, the one a return closes
  assign top_bit = in_service_reg[3] ? 4'h8 : in_service_reg[2] ? 4'h4 : in_service_reg[1] ? 4'h2 :
                   in_service_reg[0] ? 4'h1 : 4'h0;

  // ====================================================
  // in-service level stack, one bit per level
  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      in_service_reg <= 4'h0;
    end else if (grant) begin
      in_service_reg <= in_service_reg | (4'h1 << lvl);
    end else if (cpu.ret) begin
      in_service_reg <= in_service_reg & ~top_bit;
    end
  end

  // external flag clear on vectoring, transition mode only
  always_ff @(posedge clk_sys or negedge rst_n_reg) begin
    if (!rst_n_reg) begin
      ext_clear_reg <= 2'b00;
    end else begin
      ext_clear_reg[0] <= grant && (idx == 3'(FLP_SRC_EXT0)) && ext0_edge_mode;
      ext_clear_reg[1] <= grant && (idx == 3'(FLP_SRC_EXT1)) && ext1_edge_mode;
    end
  end

  assign irq_pending = allowed;
  assign irq_vector = FLP_VEC_BASE + (FLP_VEC_STEP * {5'h00, idx});
  assign ext_flag_clear = ext_clear_reg;
  assign in_service = in_service_reg;
  assign sfr_rdata = sfr_rdata_reg;

  // ====================================================
  // checks
  property p_block_equal;
    @(posedge clk_sys) disable iff (!rst_n_reg)
      (found && in_service_reg[lvl]) |-> !irq_pending;
  endproperty
  a_block_equal: assert property (p_block_equal) else $error("request taken over equal level");

  property p_hold;
    @(posedge clk_sys) disable iff (!rst_n_reg)
      (cpu.take && !irq_pending) |=> $stable(in_service_reg) || $past(cpu.ret);
  endproperty
  a_hold: assert property (p_hold) else $error("blocked request changed service");

  property p_preempt;
    @(posedge clk_sys) disable iff (!rst_n_reg)
      grant |=> in_service_reg[$past(lvl)] && ((in_service_reg & ~$past(in_service_reg)) != 4'h0);
  endproperty
  a_preempt: assert property (p_preempt) else $error("grant did not mark level");

  property p_resume;
    @(posedge clk_sys) disable iff (!rst_n_reg)
      (cpu.ret && !grant && in_service_reg != 4'h0) |=> in_service_reg == ($past(in_service_reg) & ~$past(top_bit));
  endproperty
  a_resume: assert property (p_resume) else $error("return did not restore lower level");

  property p_level_clear;
    @(posedge clk_sys) disable iff (!rst_n_reg)
      !ext0_edge_mode |=> !ext_clear_reg[0];
  endproperty
  a_level_clear: assert property (p_level_clear) else $error("level flag cleared");

  property p_edge_clear;
    @(posedge clk_sys) disable iff (!rst_n_reg)
      (grant && idx == 3'(FLP_SRC_EXT0) && ext0_edge_mode) |=> ext_clear_reg[0];
  endproperty
  a_edge_clear: assert property (p_edge_clear) else $error("edge flag not cleared");

  // second pin: clear pulse follows its own mode bit only
  property p_edge_clear_ext1;
    @(posedge clk_sys) disable iff (!rst_n_reg)
      (grant && idx == 3'(FLP_SRC_EXT1)) |=> (ext_clear_reg[1] == $past(ext1_edge_mode));
  endproperty
  a_edge_clear_ext1: assert property (p_edge_clear_ext1) else $error("pin 1 flag clear wrong");

  property p_global;
    @(posedge clk_sys) disable iff (!rst_n_reg)
      !enable_reg[FLP_GLOBAL_BIT] |-> !irq_pending;
  endproperty
  a_global: assert property (p_global) else $error("pending while globally off");

  property p_vector;
    @(posedge clk_sys) disable iff (!rst_n_reg)
      (irq_pending && src_flag[0] && enable_reg[0] && priority_low_reg[0] && priority_upper_reg[0]) |->
        irq_vector == FLP_VEC_BASE;
  endproperty
  a_vector: assert property (p_vector) else $error("ext0 at top level not first");

  property p_upper;
    @(posedge clk_sys) disable iff (!rst_n_reg)
      (sfr.wr && sfr.addr == FLP_ADDR_PRIO_UPPER) |=> priority_upper_reg == $past(sfr.wdata[5:0]);
  endproperty
  a_upper: assert property (p_upper) else $error("upper priority write lost");
endmodule // flp_irq_ctrl

/* File: tb/flp_flag_model.sv */
`timescale 1ns/1ps
// ====================================================
// peripheral request flags facing the controller
module flp_flag_model (
  input wire logic clk_sys,
  input wire logic resetn,
  input wire logic [5:0] raise,
  input wire logic [5:0] lower,
  input wire logic [1:0] ext_flag_clear,
  output logic [5:0] src_flag
);
  // set by peripherals, cleared by software or by the pin clear pulse; a new event wins over a clear
  always_ff @(posedge clk_sys or negedge resetn) begin
    if (!resetn) begin
      src_flag <= 6'h00;
    end else begin
      src_flag <= (src_flag & ~lower & ~{3'h0, ext_flag_clear[1], 1'h0, ext_flag_clear[0]}) | raise;
    end
  end
endmodule // flp_flag_model

/* File: tb/flp_irq_ctrl_tb_top.sv */
`timescale 1ns/1ps
// ====================================================
// bench for the priority controller
module flp_irq_ctrl_tb_top;
  import flp_pkg::*;
  logic clk_sys, resetn, ext0_edge_mode, ext1_edge_mode, irq_pending;
  flp_sfr_s sfr;
  flp_cpu_s cpu;
  logic [7:0] sfr_rdata, irq_vector;
  logic [5:0] src_flag, raise, lower;
  logic [1:0] ext_flag_clear;
  logic [3:0] in_service;
  int num_errors = 0;
  int total_checks = 0;
  flp_irq_ctrl i_flp_irq_ctrl (.clk_sys(clk_sys), .resetn(resetn), .sfr(sfr), .sfr_rdata(sfr_rdata),
    .src_flag(src_flag), .ext0_edge_mode(ext0_edge_mode), .ext1_edge_mode(ext1_edge_mode), .cpu(cpu),
    .irq_pending(irq_pending), .irq_vector(irq_vector), .ext_flag_clear(ext_flag_clear), .in_service(in_service));
  flp_flag_model i_flp_flag_model (.clk_sys(clk_sys), .resetn(resetn), .raise(raise), .lower(lower),
    .ext_flag_clear(ext_flag_clear), .src_flag(src_flag));
  // free-running clock
  initial begin
    clk_sys = 1'h0;
    forever #4 clk_sys = ~clk_sys;
  end
  task automatic report_and_stop;
    if (num_errors == 0 && total_checks > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      num_errors++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic sfr_wr(input logic [7:0] a, input logic [7:0] d);
    sfr = '{1'h1, 1'h0, a, d};
    @(negedge clk_sys);
    sfr.wr = 1'h0;
  endtask
  task automatic sfr_rd(input logic [7:0] a, input logic [7:0] exp);
    sfr = '{1'h0, 1'h1, a, 8'h00};
    @(negedge clk_sys);
    sfr.rd = 1'h0;
    chk(sfr_rdata, exp);
  endtask
  task automatic cpu_op(input logic t, input logic r);
    cpu = '{t, r};
    @(negedge clk_sys);
    cpu = '{1'h0, 1'h0};
  endtask
  task automatic flags(input logic [5:0] r, input logic [5:0] l);
    raise = r;
    lower = l;
    @(negedge clk_sys);
    raise = 6'h00;
    lower = 6'h00;
  endtask
  // watchdog against a hang
  initial begin
    #(8 * 4000);
    num_errors++;
    report_and_stop();
  end
  // main sequence
  initial begin
    logic [1:0] lv;
    resetn = 1'h0;
    sfr = '0;
    cpu = '0;
    raise = 6'h00;
    lower = 6'h00;
    ext0_edge_mode = 1'h0;
    ext1_edge_mode = 1'h0;
    repeat (3) @(negedge clk_sys);
    resetn = 1'h1;
    repeat (3) @(negedge clk_sys);
    sfr_rd(FLP_ADDR_ENABLE, FLP_ENABLE_RST);
    sfr_rd(FLP_ADDR_PRIO_UPPER, FLP_PRIO_RST);
    sfr_wr(FLP_ADDR_ENABLE, 8'hFF);
    sfr_rd(FLP_ADDR_ENABLE, 8'hBF);
    sfr_wr(8'h55, 8'hFF);
    sfr_rd(8'h55, 8'h00);
    sfr_wr(FLP_ADDR_PRIO_UPPER, 8'h3F);
    sfr_rd(FLP_ADDR_PRIO_UPPER, 8'h3F);
    sfr_wr(FLP_ADDR_PRIO_UPPER, 8'h00);
    sfr_wr(FLP_ADDR_PRIO_LOW, 8'hFF);
    sfr_rd(FLP_ADDR_PRIO_LOW, 8'h3F);
    sfr_wr(FLP_ADDR_PRIO_LOW, 8'h00);
    // all six at one level: polling order decides
    flags(6'h3F, 6'h00);
    for (int i = 0; i < 6; i++) begin
      chk(irq_vector, 8'h03 + 8'(8 * i));
      flags(6'h00, 6'(1 << i));
    end
    chk({7'h00, irq_pending}, 8'h00);
    flags(6'h21, 6'h00);
    sfr_wr(FLP_ADDR_ENABLE, 8'h3F);
    chk({7'h00, irq_pending}, 8'h00);
    sfr_wr(FLP_ADDR_ENABLE, 8'hBE);
    chk(irq_vector, 8'h2B);
    sfr_wr(FLP_ADDR_ENABLE, 8'hBF);
    // timer 2 at each level against ext0 at level 0
    for (int l = 0; l < 4; l++) begin
      lv = 2'(l);
      sfr_wr(FLP_ADDR_PRIO_UPPER, {2'h0, lv[1], 5'h00});
      sfr_wr(FLP_ADDR_PRIO_LOW, {2'h0, lv[0], 5'h00});
      chk(irq_vector, (l == 0) ? 8'h03 : 8'h2B);
      cpu_op(1'h1, 1'h0);
      chk({4'h0, in_service}, 8'h01 << l);
      chk({6'h00, ext_flag_clear}, 8'h00);
      chk({7'h00, irq_pending}, 8'h00);
      cpu_op(1'h0, 1'h1);
      chk({7'h00, irq_pending}, 8'h01);
    end
    // preemption and nesting
    flags(6'h00, 6'h20);
    cpu_op(1'h1, 1'h0);
    chk({4'h0, in_service}, 8'h01);
    flags(6'h20, 6'h00);
    chk(irq_vector, 8'h2B);
    cpu_op(1'h1, 1'h0);
    chk({4'h0, in_service}, 8'h09);
    flags(6'h00, 6'h20);
    // a take while blocked must leave service untouched
    cpu_op(1'h1, 1'h0);
    chk({4'h0, in_service}, 8'h09);
    cpu_op(1'h0, 1'h1);
    chk({4'h0, in_service}, 8'h01);
    cpu_op(1'h0, 1'h1);
    chk({4'h0, in_service}, 8'h00);
    // take and return in one cycle: the take wins
    cpu_op(1'h1, 1'h1);
    chk({4'h0, in_service}, 8'h01);
    cpu_op(1'h0, 1'h1);
    chk({4'h0, in_service}, 8'h00);
    // transition mode clears the pin flag on vectoring
    ext0_edge_mode = 1'h1;
    cpu_op(1'h1, 1'h0);
    chk({6'h00, ext_flag_clear}, 8'h01);
    @(negedge clk_sys);
    chk({2'h0, src_flag}, 8'h00);
    chk({7'h00, irq_pending}, 8'h00);
    cpu_op(1'h0, 1'h1);
    // second pin, level mode then transition mode
    flags(6'h04, 6'h00);
    chk(irq_vector, 8'h13);
    cpu_op(1'h1, 1'h0);
    chk({6'h00, ext_flag_clear}, 8'h00);
    @(negedge clk_sys);
    chk({2'h0, src_flag}, 8'h04);
    cpu_op(1'h0, 1'h1);
    ext1_edge_mode = 1'h1;
    cpu_op(1'h1, 1'h0);
    chk({6'h00, ext_flag_clear}, 8'h02);
    @(negedge clk_sys);
    chk({2'h0, src_flag}, 8'h00);
    cpu_op(1'h0, 1'h1);
    chk({4'h0, in_service}, 8'h00);
    report_and_stop();
  end
endmodule // flp_irq_ctrl_tb_top
